// file: logic/bmw_pkg.sv
// Constants and types shared by the bus monitor and core watchdog block
package bmw_pkg;

    // Register byte offsets on the APB port
    localparam logic [7:0]  BUS_TIMEOUT_CONTROL_OFS  = 8'h00;
    localparam logic [7:0]  WATCHDOG_CONTROL_OFS     = 8'h04;
    localparam logic [7:0]  WATCHDOG_SERVICE_OFS     = 8'h08;
    localparam logic [7:0]  SYSTEM_IRQ_STATUS_OFS    = 8'h0C;
    localparam logic [7:0]  FAULT_IRQ_ENABLE_OFS     = 8'h10;

    // bus_timeout_control fields
    localparam int          BT_ENABLE_BIT            = 3;
    localparam int          BT_PERIOD_LSB            = 0;
    localparam logic        BT_ENABLE_RST            = 1'b1;
    localparam logic [2:0]  BT_PERIOD_RST            = 3'h0;

    // watchdog_control fields
    localparam int          WC_LOCK_BIT              = 15;
    localparam int          WC_RUN_HALT_BIT          = 8;
    localparam int          WC_ENABLE_BIT            = 7;
    localparam int          WC_RESP_LSB              = 5;
    localparam int          WC_PERIOD_LSB            = 0;
    localparam logic        WC_LOCK_RST              = 1'b0;
    localparam logic        WC_RUN_HALT_RST          = 1'b0;
    localparam logic        WC_ENABLE_RST            = 1'b0;
    localparam logic [4:0]  WC_PERIOD_RST            = 5'h00;

    // system_irq_status and fault_irq_enable_reg fields
    localparam int          ST_FAULT_BIT             = 1;
    localparam int          ST_WDOG_BIT              = 0;
    localparam int          FE_ENABLE_BIT            = 0;

    // Bus monitor: longest limit, halved per step of the period code
    localparam logic [10:0] BM_MAX_CYCLES            = 11'h400;

    // Watchdog: period is 2**n cycles, n never below this
    localparam logic [4:0]  WD_MIN_EXP               = 5'h08;
    localparam logic [4:0]  WD_QUARTER_SHIFT         = 5'h02;

    // Service codes
    localparam logic [7:0]  SVC_FIRST                = 8'h55;
    localparam logic [7:0]  SVC_SECOND               = 8'hAA;

    // Timeout responses, in field encoding order 00..11
    typedef enum logic [1:0] {
        RESP_IRQ,
        RESP_IRQ_THEN_RESET,
        RESP_RESET,
        RESP_WINDOW
    } bmw_resp_t;

    typedef enum logic {
        BM_IDLE,
        BM_WAIT
    } bmw_bm_state_t;

endpackage

// file: logic/bmw_top.sv
// Bus monitor timeout and core watchdog with APB register port
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ns

module bmw_top (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bus_cycle_start,
    input  wire logic        bus_cycle_term,
    output logic             bus_error_term,
    input  wire logic        core_halted,
    output logic             watchdog_irq,
    output logic             fault_irq,
    output logic             system_reset_req,
    output logic             watchdog_reset_cause
);

    // APB slave: one wait state so read data can come from a flop
    logic                    ack_ff;
    logic [31:0]             prdata_ff;
    logic [31:0]             nxt_prdata;
    logic                    hit_bt;
    logic                    hit_wc;
    logic                    hit_svc;
    logic                    hit_st;
    logic                    hit_fe;
    logic                    wr_en;

    // Registers
    logic                    bt_en_ff;
    logic [2:0]              bt_per_ff;
    logic                    wd_lock_ff;
    logic                    wd_halt_run_ff;
    logic                    wd_en_ff;
    bmw_pkg::bmw_resp_t      wd_resp_ff;
    logic [4:0]              wd_per_ff;
    logic                    fault_flag_ff;
    logic                    wd_irq_flag_ff;
    logic                    fault_irq_en_ff;

    // Bus monitor
    bmw_pkg::bmw_bm_state_t  bm_state_ff;
    logic [10:0]             bm_cnt_ff;
    logic [10:0]             bm_limit;
    logic                    bm_fire;
    logic                    bm_err_ff;

    // Watchdog
    logic [31:0]             wd_cnt_ff;
    logic [4:0]              wd_exp;
    logic [31:0]             wd_last;
    logic [31:0]             wd_win_start;
    logic                    wd_run;
    logic                    wd_tmo;
    logic                    svc_wr;
    logic                    svc_first;
    logic                    svc_second;
    logic                    svc_early;
    logic                    svc_bad;
    logic                    svc_done;
    logic                    armed_ff;
    logic                    pend_ff;
    logic                    wd_irq_set;
    logic                    rst_fire;
    logic                    rst_req_ff;
    logic                    rst_cause_ff;

    assign hit_bt  = (paddr == bmw_pkg::BUS_TIMEOUT_CONTROL_OFS);
    assign hit_wc  = (paddr == bmw_pkg::WATCHDOG_CONTROL_OFS);
    assign hit_svc = (paddr == bmw_pkg::WATCHDOG_SERVICE_OFS);
    assign hit_st  = (paddr == bmw_pkg::SYSTEM_IRQ_STATUS_OFS);
    assign hit_fe  = (paddr == bmw_pkg::FAULT_IRQ_ENABLE_OFS);

    assign pready  = ack_ff & clk_en;
    assign pslverr = pready & ~(hit_bt | hit_wc | hit_svc | hit_st | hit_fe);
    assign wr_en   = psel & penable & pready & pwrite;
    assign prdata  = prdata_ff;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_ff <= 1'b0;
        end else if (clk_en) begin
            ack_ff <= psel & penable & ~ack_ff;
        end
    end

    always_comb begin
        nxt_prdata = 32'h0000_0000;
        case (paddr)
            bmw_pkg::BUS_TIMEOUT_CONTROL_OFS: begin
                nxt_prdata[bmw_pkg::BT_ENABLE_BIT] = bt_en_ff;
                nxt_prdata[bmw_pkg::BT_PERIOD_LSB +: 3] = bt_per_ff;
            end
            bmw_pkg::WATCHDOG_CONTROL_OFS: begin
                nxt_prdata[bmw_pkg::WC_LOCK_BIT] = wd_lock_ff;
                nxt_prdata[bmw_pkg::WC_RUN_HALT_BIT] = wd_halt_run_ff;
                nxt_prdata[bmw_pkg::WC_ENABLE_BIT] = wd_en_ff;
                nxt_prdata[bmw_pkg::WC_RESP_LSB +: 2] = wd_resp_ff;
                nxt_prdata[bmw_pkg::WC_PERIOD_LSB +: 5] = wd_per_ff;
            end
            bmw_pkg::SYSTEM_IRQ_STATUS_OFS: begin
                nxt_prdata[bmw_pkg::ST_FAULT_BIT] = fault_flag_ff;
                nxt_prdata[bmw_pkg::ST_WDOG_BIT] = wd_irq_flag_ff;
            end
            bmw_pkg::FAULT_IRQ_ENABLE_OFS: begin
                nxt_prdata[bmw_pkg::FE_ENABLE_BIT] = fault_irq_en_ff;
            end
            default: begin
                nxt_prdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata_ff <= 32'h0000_0000;
        end else if (clk_en && psel && penable && !ack_ff) begin
            prdata_ff <= nxt_prdata;
        end
    end

    // Bus timeout control register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bt_en_ff  <= bmw_pkg::BT_ENABLE_RST;
            bt_per_ff <= bmw_pkg::BT_PERIOD_RST;
        end else if (clk_en && wr_en && hit_bt) begin
            bt_en_ff  <= pwdata[bmw_pkg::BT_ENABLE_BIT];
            bt_per_ff <= pwdata[bmw_pkg::BT_PERIOD_LSB +: 3];
        end
    end

    // Watchdog control register; lock survives everything but reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wd_lock_ff     <= bmw_pkg::WC_LOCK_RST;
            wd_halt_run_ff <= bmw_pkg::WC_RUN_HALT_RST;
            wd_en_ff       <= bmw_pkg::WC_ENABLE_RST;
            wd_resp_ff     <= bmw_pkg::RESP_IRQ;
            wd_per_ff      <= bmw_pkg::WC_PERIOD_RST;
        end else if (clk_en && wr_en && hit_wc && !wd_lock_ff) begin
            wd_lock_ff     <= pwdata[bmw_pkg::WC_LOCK_BIT];
            wd_halt_run_ff <= pwdata[bmw_pkg::WC_RUN_HALT_BIT];
            wd_en_ff       <= pwdata[bmw_pkg::WC_ENABLE_BIT];
            wd_resp_ff     <= bmw_pkg::bmw_resp_t'(pwdata[bmw_pkg::WC_RESP_LSB +: 2]);
            wd_per_ff      <= pwdata[bmw_pkg::WC_PERIOD_LSB +: 5];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fault_irq_en_ff <= 1'b0;
        end else if (clk_en && wr_en && hit_fe) begin
            fault_irq_en_ff <= pwdata[bmw_pkg::FE_ENABLE_BIT];
        end
    end

    // Bus monitor
    assign bm_limit = bmw_pkg::BM_MAX_CYCLES >> bt_per_ff;
    assign bm_fire  = bt_en_ff && (bm_state_ff == bmw_pkg::BM_WAIT) && !bus_cycle_start
                      && !bus_cycle_term && (bm_cnt_ff == bm_limit - 11'h001);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bm_state_ff <= bmw_pkg::BM_IDLE;
            bm_cnt_ff   <= 11'h000;
        end else if (clk_en) begin
            case (bm_state_ff)
                bmw_pkg::BM_IDLE: begin
                    if (bus_cycle_start && bt_en_ff) begin
                        bm_state_ff <= bmw_pkg::BM_WAIT;
                    end
                    bm_cnt_ff <= 11'h000;
                end
                bmw_pkg::BM_WAIT: begin
                    if (!bt_en_ff) begin
                        bm_state_ff <= bmw_pkg::BM_IDLE;
                    end else if (bus_cycle_start) begin
                        bm_cnt_ff <= 11'h000;
                    end else if (bus_cycle_term || bm_fire) begin
                        bm_state_ff <= bmw_pkg::BM_IDLE;
                    end else begin
                        bm_cnt_ff <= bm_cnt_ff + 11'h001;
                    end
                end
                default: begin
                    bm_state_ff <= bmw_pkg::BM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bm_err_ff <= 1'b0;
        end else if (clk_en) begin
            bm_err_ff <= bm_fire;
        end
    end

    // Status flags: a set in the clearing cycle wins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fault_flag_ff <= 1'b0;
        end else if (clk_en) begin
            fault_flag_ff <= bm_fire | (fault_flag_ff
                             & ~(wr_en & hit_st & pwdata[bmw_pkg::ST_FAULT_BIT]));
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wd_irq_flag_ff <= 1'b0;
        end else if (clk_en) begin
            wd_irq_flag_ff <= wd_irq_set | (wd_irq_flag_ff
                              & ~(wr_en & hit_st & pwdata[bmw_pkg::ST_WDOG_BIT]));
        end
    end

    // Watchdog timing
    assign wd_exp       = (wd_per_ff < bmw_pkg::WD_MIN_EXP) ? bmw_pkg::WD_MIN_EXP
                                                             : wd_per_ff;
    assign wd_last      = (32'h0000_0001 << wd_exp) - 32'h0000_0001;
    assign wd_win_start = 32'h0000_0003 << (wd_exp - bmw_pkg::WD_QUARTER_SHIFT);
    assign wd_run       = clk_en && wd_en_ff && (wd_halt_run_ff || !core_halted);
    assign wd_tmo       = wd_run && (wd_cnt_ff == wd_last);

    // Service port decode
    assign svc_wr     = wr_en && hit_svc && wd_en_ff;
    assign svc_first  = (pwdata[7:0] == bmw_pkg::SVC_FIRST);
    assign svc_second = (pwdata[7:0] == bmw_pkg::SVC_SECOND);
    assign svc_early  = svc_wr && (wd_resp_ff == bmw_pkg::RESP_WINDOW)
                        && (wd_cnt_ff < wd_win_start);
    assign svc_bad    = svc_wr && !svc_first && !svc_second && !wd_irq_flag_ff;
    assign svc_done   = svc_wr && svc_second && armed_ff && !svc_early;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            armed_ff <= 1'b0;
        end else if (clk_en) begin
            if (!wd_en_ff || svc_done || svc_early) begin
                armed_ff <= 1'b0;
            end else if (svc_wr && svc_first) begin
                armed_ff <= 1'b1;
            end
        end
    end

    // Disabled counter is held at zero so enabling starts a full period
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wd_cnt_ff <= 32'h0000_0000;
        end else if (clk_en) begin
            if (!wd_en_ff) begin
                wd_cnt_ff <= 32'h0000_0000;
            end else if (svc_done || wd_tmo) begin
                wd_cnt_ff <= 32'h0000_0000;
            end else if (wd_run) begin
                wd_cnt_ff <= wd_cnt_ff + 32'h0000_0001;
            end
        end
    end

    // First timeout in two-stage mode waits for service
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pend_ff <= 1'b0;
        end else if (clk_en) begin
            if (!wd_en_ff || svc_done) begin
                pend_ff <= 1'b0;
            end else if (wd_tmo && wd_resp_ff == bmw_pkg::RESP_IRQ_THEN_RESET) begin
                pend_ff <= 1'b1;
            end
        end
    end

    assign wd_irq_set = wd_tmo && ((wd_resp_ff == bmw_pkg::RESP_IRQ)
                        || (wd_resp_ff == bmw_pkg::RESP_IRQ_THEN_RESET && !pend_ff));
    assign rst_fire   = (wd_tmo && ((wd_resp_ff == bmw_pkg::RESP_RESET)
                        || (wd_resp_ff == bmw_pkg::RESP_WINDOW)
                        || (wd_resp_ff == bmw_pkg::RESP_IRQ_THEN_RESET && pend_ff)))
                        || svc_bad || svc_early;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rst_req_ff   <= 1'b0;
            rst_cause_ff <= 1'b0;
        end else if (clk_en) begin
            rst_req_ff   <= rst_fire;
            rst_cause_ff <= rst_fire;
        end
    end

    assign bus_error_term       = bm_err_ff;
    assign watchdog_irq         = wd_irq_flag_ff;
    assign fault_irq            = fault_flag_ff & fault_irq_en_ff;
    assign system_reset_req     = rst_req_ff;
    assign watchdog_reset_cause = rst_cause_ff;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    bm_timeout_a: assert property (clk_en && bm_fire |=> bus_error_term && fault_flag_ff)
        else $error("bus monitor timeout did not end cycle");
    bm_limit_a: assert property (bus_error_term |-> $past(bm_cnt_ff) == $past(bm_limit) - 11'h001
        && $past(bm_limit) == (11'h400 >> $past(bt_per_ff)))
        else $error("bus monitor fired at wrong count");
    fault_irq_a: assert property (fault_irq == (fault_flag_ff && fault_irq_en_ff))
        else $error("fault irq not gated by enable");
    bm_off_a: assert property (clk_en && !bt_en_ff |=> !bus_error_term)
        else $error("disabled monitor raised error");
    wd_lock_a: assert property (wd_lock_ff |=> wd_lock_ff && $stable(wd_per_ff)
        && $stable(wd_en_ff) && $stable(wd_resp_ff))
        else $error("locked watchdog control changed");
    halt_pause_a: assert property (clk_en && wd_en_ff && core_halted && !wd_halt_run_ff
        && !svc_done |=> $stable(wd_cnt_ff))
        else $error("watchdog counted while halted");
    irq_mode_a: assert property (wd_tmo && wd_resp_ff == bmw_pkg::RESP_IRQ
        |=> wd_irq_flag_ff && !system_reset_req)
        else $error("irq response misbehaved");
    reset_mode_a: assert property (wd_tmo && wd_resp_ff == bmw_pkg::RESP_RESET
        |=> system_reset_req && watchdog_reset_cause)
        else $error("reset response missing");
    window_early_a: assert property (svc_wr && wd_resp_ff == bmw_pkg::RESP_WINDOW
        && wd_cnt_ff < wd_win_start |=> system_reset_req)
        else $error("early window write did not reset");
    reset_cause_a: assert property (clk_en && $past(clk_en) && system_reset_req
        |-> watchdog_reset_cause && $past(wd_tmo || svc_wr))
        else $error("reset without cause flag or watchdog event");
    bad_code_a: assert property (svc_bad |=> system_reset_req)
        else $error("bad service code did not reset");
    service_a: assert property (svc_done |=> wd_cnt_ff == 32'h0000_0000)
        else $error("service did not restart counter");

    bm_fire_c: cover property (bm_fire);
    svc_done_c: cover property (svc_done);
    window_rst_c: cover property (wd_tmo && wd_resp_ff == bmw_pkg::RESP_WINDOW);
    two_stage_c: cover property (wd_tmo && pend_ff);

endmodule

// file: test/bmw_bus_partner.sv
// Bus slave stand-in that opens cycles and answers after a set delay
`timescale 1ns/1ns
module bmw_bus_partner (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        req,
    input  wire logic [11:0] delay,
    input  wire logic        bus_error_term,
    output logic             bus_cycle_start,
    output logic             bus_cycle_term
);
    logic [11:0] cnt_ff;
    logic        busy_ff;

    // A new request abandons the old cycle, so a slow slave never blocks later tests
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_ff <= 12'h000;
            busy_ff <= 1'b0;
            bus_cycle_start <= 1'b0;
            bus_cycle_term <= 1'b0;
        end else begin
            bus_cycle_start <= req;
            bus_cycle_term <= busy_ff && cnt_ff == delay;
            cnt_ff <= req ? 12'h001 : cnt_ff + 12'h001;
            busy_ff <= req || (busy_ff && cnt_ff != delay && !bus_error_term);
        end
    end
endmodule

// file: test/bus_monitor_and_core_watchdog_bench.sv
// Self-checking bench for the bus monitor and core watchdog
`timescale 1ns/1ns
module bus_monitor_and_core_watchdog_bench;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        core_halted = 1'b0;
    logic        clk_en = 1'b1;
    logic        rst_tail;
    logic        req = 1'b0;
    logic [11:0] delay = 12'hFFF;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, bus_cycle_start, bus_cycle_term, bus_error_term;
    logic        watchdog_irq, fault_irq, system_reset_req, watchdog_reset_cause;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          n;
    int          p;

    always #5 clk = ~clk;

    bmw_top dut (.clk(clk), .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_cycle_start(bus_cycle_start), .bus_cycle_term(bus_cycle_term),
        .bus_error_term(bus_error_term), .core_halted(core_halted),
        .watchdog_irq(watchdog_irq), .fault_irq(fault_irq),
        .system_reset_req(system_reset_req), .watchdog_reset_cause(watchdog_reset_cause));

    bmw_bus_partner slave (.clk(clk), .reset(reset), .req(req), .delay(delay),
        .bus_error_term(bus_error_term), .bus_cycle_start(bus_cycle_start),
        .bus_cycle_term(bus_cycle_term));

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Waits for pready however long it takes; only the cycle ceiling ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        chk("pslverr", pslverr, (a > 8'h10) || (a[1:0] != 2'h0));
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        // A reset pulse launched by the write stands only through this edge
        rst_tail = system_reset_req;
    endtask

    function automatic logic pick(input int which);
        case (which)
            0: return bus_error_term === 1'b1;
            1: return system_reset_req === 1'b1;
            2: return watchdog_irq === 1'b1;
            default: return bus_cycle_start === 1'b1;
        endcase
    endfunction

    // Edges counted until the chosen output is seen high, capped at lim
    task automatic wait_for(input int which, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!pick(which) && n < lim);
    endtask

    task automatic issue(input int lim);
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        wait_for(3, 10);
        wait_for(0, lim);
    endtask

    // Each watchdog test starts from a disabled, cleared counter
    task automatic wd(input logic [31:0] v);
        apb(1, 8'h04, 32'h0);
        apb(1, 8'h04, v);
    endtask

    // Expected figures from the rules; only the bus monitor figure adds one edge of output latency
    function automatic int bm_edges(input int code);
        return (1024 >> code) + 1;
    endfunction

    function automatic int wd_period(input int code);
        return 1 << ((code < 8) ? 8 : code);
    endfunction

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            error_cnt++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(99));
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        apb(0, 8'h00, 0);
        chk("bt_ctrl", rd, 32'h8);
        apb(0, 8'h04, 0);
        chk("wd_ctrl", rd, 32'h0);
        apb(0, 8'h14, 0);
        chk("unmapped", err, 1);
        for (int c = 0; c < 8; c++) begin
            apb(1, 8'h00, 32'h8 | c);
            issue(1100);
            chk("bm_limit", n, bm_edges(c));
        end
        apb(0, 8'h0C, 0);
        chk("fault_flag", rd[1], 1);
        chk("fault_irq_off", fault_irq, 0);
        apb(1, 8'h10, 32'h1);
        chk("fault_irq_on", fault_irq, 1);
        apb(1, 8'h0C, 32'h0);
        chk("fault_keep", fault_irq, 1);
        apb(1, 8'h0C, 32'h2);
        chk("fault_clear", fault_irq, 0);
        delay <= 12'($urandom_range(1, 6));
        issue(20);
        chk("quick_term", n, 20);
        delay <= 12'hFFF;
        apb(1, 8'h00, 32'h7);
        issue(40);
        chk("bm_off", n, 40);
        $display("Test bus monitor done");
        p = $urandom_range(0, 8);
        wd(32'hC0 | p);
        wait_for(1, 400);
        chk("wd_reset", n, wd_period(p));
        chk("wd_cause", watchdog_reset_cause, 1);
        repeat (150) @(posedge clk);
        apb(1, 8'h08, 32'h55);
        apb(1, 8'h08, 32'hAA);
        wait_for(1, 400);
        chk("wd_service", n, 256);
        apb(1, 8'h08, $urandom_range(0, 84));
        chk("wd_bad_code", rst_tail, 1);
        wait_for(1, 10);
        chk("wd_bad_once", n, 10);
        wd(32'h80);
        wait_for(2, 400);
        chk("wd_irq", n, 256);
        wait_for(1, 300);
        chk("wd_irq_no_rst", n, 300);
        apb(1, 8'h0C, 32'h0);
        chk("irq_keep", watchdog_irq, 1);
        apb(1, 8'h0C, 32'h1);
        chk("irq_clear", watchdog_irq, 0);
        wd(32'hA0);
        wait_for(2, 400);
        chk("wd_first", n, 256);
        wait_for(1, 400);
        chk("wd_second", n, 256);
        chk("wd_cause2", watchdog_reset_cause, 1);
        wd(32'hE0);
        apb(1, 8'h08, 32'h55);
        chk("win_early", rst_tail, 1);
        wd(32'hE0);
        repeat (200) @(posedge clk);
        apb(1, 8'h08, 32'h55);
        apb(1, 8'h08, 32'hAA);
        wait_for(1, 400);
        chk("win_late", n, 256);
        $display("Test watchdog modes done");
        // One count is taken before the halt lands, so the remainder is 255 plus latency
        wd(32'hC0);
        core_halted <= 1'b1;
        wait_for(1, 300);
        chk("halt_pause", n, 300);
        core_halted <= 1'b0;
        wait_for(1, 300);
        chk("halt_resume", n, 256);
        wd(32'h1C0);
        core_halted <= 1'b1;
        wait_for(1, 400);
        chk("halt_run", n, 256);
        apb(0, 8'h04, 0);
        chk("wd_rw", rd, 32'h1C0);
        core_halted <= 1'b0;
        // Clock enable low must freeze the count, so the period stretches by the gap
        wd(32'hC0);
        clk_en <= 1'b0;
        wait_for(1, 100);
        chk("frozen", n, 100);
        clk_en <= 1'b1;
        wait_for(1, 400);
        chk("thawed", n, 256);
        wd(32'h8000);
        apb(1, 8'h04, 32'h80);
        apb(0, 8'h04, 0);
        chk("wd_lock", rd, 32'h8000);
        $display("Test halt and lock done");
        end_of_test();
    end
endmodule
